// ### rtl/poc_cfg.svh
`ifndef POC_CFG_SVH
`define POC_CFG_SVH

// ==========================================
// Register offsets
`define POC_DEP_BASE   8'h0E
`define POC_DEP_BYTES  3
`define POC_TMO_BASE   8'h26
`define POC_OPOL       8'h3A
`define POC_GPOL       8'h3B
`define POC_MRDEP      8'h40
`define POC_MSEL       8'h41
`define POC_MLVL       8'h42
`define POC_STAT       8'h43

// ==========================================
// Dependency mask layout
`define POC_DEP_W      24
`define POC_DEP_GPI    6
`define POC_DEP_OUT    10

// ==========================================
// Per-output register bit of output 1 in the five-output variant
`define POC_BIT_BASE_SMALL 2

// ==========================================
// Timing
`define POC_CLK_NS     8
`define POC_TMO_MIN_NS 25000
`define POC_TMO_MAX_SH 5'd16
`define POC_CNT_W      28

`endif

// ### rtl/poc_pkg.sv
package poc_pkg;

  // Register write request
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } poc_reg_wr_type;

  // Per-output sequencing state
  typedef enum logic [1:0] {
    POC_ASSERTED,
    POC_TIMING,
    POC_RELEASED
  } poc_state_type;

endpackage

// ### rtl/poc_top.sv
// How it works
// - Eight outputs, or five in the small variant, each configured on its own.
// - An output stays active until its timeout expires and all conditions hold.
// - An output with no dependency at all stays active forever.
// - Active-high outputs drive high when asserted; active-low outputs drive low.
// - Manual reset alone never counts as a dependency of an output.
// - Positive monitors give fault 0 when under undervoltage or over overvoltage.
// - Bipolar monitor faults when less negative than UV or more negative than OV.
// - Registers 0Eh to 3Ah and 40h hold the output configuration.
// - Each output has its own timer, 25 us up to about 1600 ms.
// - Bits 0 to 3 of the polarity register set logic input levels, 1 = high.
// - A manual-reset dependency bit of 1 asserts the output while reset is low.
// - Output bits run 0 to 7; the five-output variant uses bits 2 to 6.
// - In margin mode, select 0 freezes an output, select 1 forces its level.
// - Margin level bit 0 drives low, 1 drives high, when select is 1.
// - Margin takes precedence over manual reset.
// - Outputs held by manual reset keep their timeout after it releases.

`include "poc_cfg.svh"

module poc_top #(
  parameter int NUM_OUT  = 8,
  parameter int NUM_MON  = 6,
  parameter int TMO_BASE = (`POC_TMO_MIN_NS + `POC_CLK_NS - 1) / `POC_CLK_NS
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire poc_pkg::poc_reg_wr_type reg_wr,
  input  wire logic [7:0]             reg_rd_addr,
  output      logic [7:0]             reg_rd_data,
  input  wire logic [NUM_MON-2:0]     pos_below_uv,
  input  wire logic [NUM_MON-2:0]     pos_above_ov,
  input  wire logic                   bip_less_neg_uv,
  input  wire logic                   bip_more_neg_ov,
  input  wire logic [3:0]             general_logic_inputs,
  input  wire logic                   manual_reset_in_n,
  input  wire logic                   margin_in_n,
  output      logic [NUM_OUT-1:0]     sequenced_output
);

  // ==========================================
  // Elaboration checks
  localparam int BIT_BASE = (NUM_OUT == 8) ? 0 : `POC_BIT_BASE_SMALL;

  generate
    if (!((NUM_OUT == 8 && NUM_MON == 6) || (NUM_OUT == 5 && NUM_MON == 4))) begin : g_chk
      $error("poc_top: NUM_OUT/NUM_MON must be 8/6 or 5/4");
    end
    if (TMO_BASE < 1 || TMO_BASE > 4095) begin : g_chk_t
      $error("poc_top: TMO_BASE out of range");
    end
  endgenerate

  // ==========================================
  // Helpers

  // Register bit used by output i in per-output bytes
  function automatic int obit(input int i);
    obit = i + BIT_BASE;
  endfunction

  // Timeout length in cycles for a code
  function automatic logic [`POC_CNT_W-1:0] tmo_cycles(input logic [7:0] code);
    logic [4:0]            sh;
    logic [`POC_CNT_W-1:0] base;
    sh   = (code > 8'(`POC_TMO_MAX_SH)) ? `POC_TMO_MAX_SH : code[4:0];
    base = `POC_CNT_W'(TMO_BASE);
    tmo_cycles = base << sh;
  endfunction

  // ==========================================
  // Configuration registers
  logic [`POC_DEP_W-1:0] dep_q [NUM_OUT];
  logic [7:0]            tmo_q [NUM_OUT];
  logic [7:0]            opol_q;
  logic [7:0]            gpol_q;
  logic [7:0]            mrdep_q;
  logic [7:0]            msel_q;
  logic [7:0]            mlvl_q;

  // Register writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        dep_q[i] <= '0;
        tmo_q[i] <= '0;
      end
      opol_q  <= 8'h00;
      gpol_q  <= 8'h00;
      mrdep_q <= 8'h00;
      msel_q  <= 8'h00;
      mlvl_q  <= 8'h00;
    end else if (reg_wr.we) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        for (int b = 0; b < `POC_DEP_BYTES; b++) begin
          if (reg_wr.addr == 8'(`POC_DEP_BASE + `POC_DEP_BYTES * i + b)) begin
            dep_q[i][8*b +: 8] <= reg_wr.data;
          end
        end
        if (reg_wr.addr == 8'(`POC_TMO_BASE + i)) begin
          tmo_q[i] <= reg_wr.data;
        end
      end
      case (reg_wr.addr)
        `POC_OPOL:  opol_q  <= reg_wr.data;
        `POC_GPOL:  gpol_q  <= {4'h0, reg_wr.data[3:0]};
        `POC_MRDEP: mrdep_q <= reg_wr.data;
        `POC_MSEL:  msel_q  <= reg_wr.data;
        `POC_MLVL:  mlvl_q  <= reg_wr.data;
        default:    ;
      endcase
    end
  end

  // ==========================================
  // Condition vector (1 = condition met)
  logic [NUM_MON-1:0] mon_ok;
  logic [3:0]         gpi_ok;
  logic [NUM_OUT-1:0] asserted;
  logic [`POC_DEP_W-1:0] cond;

  // Monitor status, fault shows as 0
  always_comb begin
    mon_ok[0] = ~(pos_below_uv[0] | pos_above_ov[0]);
    mon_ok[1] = ~(bip_less_neg_uv | bip_more_neg_ov);
    for (int m = 2; m < NUM_MON; m++) begin
      mon_ok[m] = ~(pos_below_uv[m-1] | pos_above_ov[m-1]);
    end
  end

  // Logic input is met while at its inactive level
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      gpi_ok[g] = general_logic_inputs[g] ^ gpol_q[g];
    end
  end

  // Assemble the condition vector; other outputs count when deasserted
  always_comb begin
    cond = '0;
    cond[NUM_MON-1:0] = mon_ok;
    cond[`POC_DEP_GPI +: 4] = gpi_ok;
    cond[`POC_DEP_OUT +: NUM_OUT] = ~asserted;
  end

  // ==========================================
  // Per-output fault evaluation
  logic [NUM_OUT-1:0] has_dep;
  logic [NUM_OUT-1:0] fault;
  logic               margin_on;

  assign margin_on = ~margin_in_n;

  // Fault when a dependency fails or manual reset holds it
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      has_dep[i] = |dep_q[i];
      fault[i]   = ~has_dep[i]
                 | (|(dep_q[i] & ~cond))
                 | (mrdep_q[obit(i)] & ~manual_reset_in_n);
    end
  end

  // ==========================================
  // Sequencing state and timers
  poc_pkg::poc_state_type st_q [NUM_OUT];
  logic [`POC_CNT_W-1:0]  cnt_q [NUM_OUT];

  // State advances only outside margin mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        st_q[i] <= poc_pkg::POC_ASSERTED;
      end
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (!margin_on) begin
          case (st_q[i])
            poc_pkg::POC_ASSERTED: begin
              if (!fault[i]) begin
                st_q[i] <= poc_pkg::POC_TIMING;
              end
            end
            poc_pkg::POC_TIMING: begin
              if (fault[i]) begin
                st_q[i] <= poc_pkg::POC_ASSERTED;
              end else if (cnt_q[i] >= tmo_cycles(tmo_q[i]) - 1'b1) begin
                st_q[i] <= poc_pkg::POC_RELEASED;
              end
            end
            poc_pkg::POC_RELEASED: begin
              if (fault[i]) begin
                st_q[i] <= poc_pkg::POC_ASSERTED;
              end
            end
            default: st_q[i] <= poc_pkg::POC_ASSERTED;
          endcase
        end
      end
    end
  end

  // Timeout counters hold in margin mode, otherwise restart on any fault
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (margin_on) begin
          cnt_q[i] <= cnt_q[i];
        end else if (st_q[i] == poc_pkg::POC_TIMING && !fault[i]) begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end else begin
          cnt_q[i] <= '0;
        end
      end
    end
  end

  // Asserted flags seen by other outputs and status
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      asserted[i] = (st_q[i] != poc_pkg::POC_RELEASED);
    end
  end

  // ==========================================
  // Output pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sequenced_output <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (margin_on && msel_q[obit(i)]) begin
          sequenced_output[i] <= mlvl_q[obit(i)];
        end else if (margin_on) begin
          sequenced_output[i] <= sequenced_output[i];
        end else begin
          sequenced_output[i] <= ~(asserted[i] ^ opol_q[obit(i)]);
        end
      end
    end
  end

  // ==========================================
  // Register read-back
  logic [7:0] stat;

  // Asserted state mapped to register bit positions
  always_comb begin
    stat = 8'h00;
    for (int i = 0; i < NUM_OUT; i++) begin
      stat[obit(i)] = asserted[i];
    end
  end

  // Registered read data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
    end else begin
      reg_rd_data <= 8'h00;
      for (int i = 0; i < NUM_OUT; i++) begin
        for (int b = 0; b < `POC_DEP_BYTES; b++) begin
          if (reg_rd_addr == 8'(`POC_DEP_BASE + `POC_DEP_BYTES * i + b)) begin
            reg_rd_data <= dep_q[i][8*b +: 8];
          end
        end
        if (reg_rd_addr == 8'(`POC_TMO_BASE + i)) begin
          reg_rd_data <= tmo_q[i];
        end
      end
      case (reg_rd_addr)
        `POC_OPOL:  reg_rd_data <= opol_q;
        `POC_GPOL:  reg_rd_data <= gpol_q;
        `POC_MRDEP: reg_rd_data <= mrdep_q;
        `POC_MSEL:  reg_rd_data <= msel_q;
        `POC_MLVL:  reg_rd_data <= mlvl_q;
        `POC_STAT:  reg_rd_data <= stat;
        default:    ;
      endcase
    end
  end

endmodule

// ### tb/poc_checker_assertions.sv
`include "poc_cfg.svh"

module poc_checker #(
  parameter int NUM_OUT = 8,
  parameter int NUM_MON = 6
) (
  core_clk,
  rst_n,
  reg_wr,
  reg_rd_addr,
  reg_rd_data,
  manual_reset_in_n,
  margin_in_n,
  sequenced_output
);
  timeunit 1ns;
  timeprecision 1ps;
  input wire logic                    core_clk;
  input wire logic                    rst_n;
  input wire poc_pkg::poc_reg_wr_type reg_wr;
  input wire logic [7:0]              reg_rd_addr;
  input wire logic [7:0]              reg_rd_data;
  input wire logic                    manual_reset_in_n;
  input wire logic                    margin_in_n;
  input wire logic [NUM_OUT-1:0]      sequenced_output;

  logic [7:0] opol_q, mrdep_q, msel_q, mlvl_q;

  // Register bits that belong to the outputs, in output order
  localparam int BIT_BASE = (NUM_OUT == 8) ? 0 : `POC_BIT_BASE_SMALL;
  logic [NUM_OUT-1:0] opol_o;
  logic [NUM_OUT-1:0] mrdep_o;
  logic [NUM_OUT-1:0] msel_o;
  logic [NUM_OUT-1:0] mlvl_o;

  assign opol_o  = opol_q[BIT_BASE +: NUM_OUT];
  assign mrdep_o = mrdep_q[BIT_BASE +: NUM_OUT];
  assign msel_o  = msel_q[BIT_BASE +: NUM_OUT];
  assign mlvl_o  = mlvl_q[BIT_BASE +: NUM_OUT];

  // ==========================================
  // Shadow copies of the output control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opol_q <= 8'h00;
      mrdep_q <= 8'h00;
      msel_q <= 8'h00;
      mlvl_q <= 8'h00;
    end else if (reg_wr.we) begin
      if (reg_wr.addr == 8'h3A) opol_q <= reg_wr.data;
      if (reg_wr.addr == 8'h40) mrdep_q <= reg_wr.data;
      if (reg_wr.addr == 8'h41) msel_q <= reg_wr.data;
      if (reg_wr.addr == 8'h42) mlvl_q <= reg_wr.data;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================
  // Register and output relations
  chk_unmapped_read: assert property ((reg_rd_addr == 8'hFF)[*2] |-> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_polarity_upper: assert property ((reg_rd_addr == 8'h3B)[*2] |-> reg_rd_data[7:4] == 4'h0)
    else $error("polarity upper bits set");
  chk_select_read: assert property ((reg_rd_addr == 8'h41 && !reg_wr.we)[*3] |-> reg_rd_data == msel_q)
    else $error("margin select readback wrong");
  chk_mr_dep_read: assert property ((reg_rd_addr == 8'h40 && !reg_wr.we)[*3] |-> reg_rd_data == mrdep_q)
    else $error("manual reset dependency readback wrong");
  chk_margin_force: assert property ((!margin_in_n)[*3] |->
    ((sequenced_output ^ mlvl_o) & msel_o) == '0)
    else $error("forced margin level wrong");
  chk_margin_freeze: assert property ((!margin_in_n)[*3] |->
    $stable(sequenced_output & ~msel_o))
    else $error("output moved while frozen");
  chk_mr_asserts: assert property ((!manual_reset_in_n && margin_in_n)[*3] |->
    ((sequenced_output ~^ opol_o) & mrdep_o) == mrdep_o)
    else $error("manual reset did not assert output");
  chk_mr_hold: assert property ($rose(manual_reset_in_n) && margin_in_n |=>
    (((sequenced_output ~^ opol_o) & mrdep_o) == mrdep_o)[*2])
    else $error("output released before timeout");

  // Main scenarios reached
  cover property ((!margin_in_n)[*3]);
  cover property ($rose(manual_reset_in_n));
  cover property ($fell(sequenced_output[0]));
endmodule

bind poc_top poc_checker #(.NUM_OUT(NUM_OUT), .NUM_MON(NUM_MON)) u_checker (
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
  .reg_rd_data(reg_rd_data), .manual_reset_in_n(manual_reset_in_n),
  .margin_in_n(margin_in_n), .sequenced_output(sequenced_output));

// ### tb/programmable_output_control_test.sv
module programmable_output_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    core_clk = 1'b0;
  logic                    rst_n = 1'b0;
  poc_pkg::poc_reg_wr_type reg_wr = '0;
  logic [7:0]              rd_addr = 8'h00;
  logic [7:0]              rd_data;
  logic [4:0]              uv = '0;
  logic [4:0]              ov = '0;
  logic                    buv = 1'b0;
  logic                    bov = 1'b0;
  logic [3:0]              gli = 4'hE;
  logic                    mr_n = 1'b1;
  logic                    mg_n = 1'b1;
  logic [7:0]              so;
  int                      miscompares = 0;
  int                      checks = 0;

  // ==========================================
  // Clock and device
  always #4 core_clk = ~core_clk;

  poc_top #(.NUM_OUT(8), .NUM_MON(6), .TMO_BASE(2)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd_addr(rd_addr),
    .reg_rd_data(rd_data), .pos_below_uv(uv), .pos_above_ov(ov), .bip_less_neg_uv(buv),
    .bip_more_neg_ov(bov), .general_logic_inputs(gli), .manual_reset_in_n(mr_n),
    .margin_in_n(mg_n), .sequenced_output(so));

  // ==========================================
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = '{we: 1'b1, addr: a, data: d};
    tick(1);
    reg_wr.we = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    rd_addr = a;
    tick(3);
    chk(rd_data, exp, what);
  endtask
  // Selects one fault source, or none for k above 4
  task automatic set_src(input int k);
    uv[0] = (k == 0);
    ov[0] = (k == 1);
    buv = (k == 2);
    bov = (k == 3);
    gli[0] = (k == 4);
  endtask
  // Output 1 holds through its timeout, then lets go
  task automatic expect_release();
    tick(3);
    chk(so, 8'hFF, "held during timeout");
    tick(1);
    chk(so, 8'hFE, "released after timeout");
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rd(8'h41, 8'h00, "select reset value");
    rd(8'h42, 8'h00, "level reset value");
    wr(8'h3B, 8'hFF);
    rd(8'h3B, 8'h0F, "polarity width");
    wr(8'h40, 8'hA5);
    rd(8'h40, 8'hA5, "mr dependency");
    rd(8'hFF, 8'h00, "unmapped read");
    wr(8'h40, 8'h00);
    $display("regs test done");
  endtask
  task automatic t_nodep();
    chk(so, 8'h00, "active low asserted");
    wr(8'h3A, 8'hFF);
    tick(2);
    chk(so, 8'hFF, "active high asserted");
    $display("nodep test done");
  endtask
  task automatic t_release();
    wr(8'h3B, 8'h01);
    wr(8'h26, 8'h00);
    wr(8'h0E, 8'h43);
    tick(8);
    chk(so, 8'hFE, "all conditions met");
    rd(8'h43, 8'hFE, "status asserted flags");
    rd(8'h0E, 8'h43, "dependency readback");
    for (int k = 0; k < 5; k++) begin
      set_src(k);
      tick(2);
      chk(so, 8'hFF, "fault asserts");
      set_src(9);
      expect_release();
    end
    set_src(0);
    tick(2);
    set_src(9);
    tick(2);
    set_src(0);
    tick(1);
    set_src(9);
    expect_release();
    $display("release test done");
  endtask
  task automatic t_mr();
    wr(8'h40, 8'h03);
    mr_n = 1'b0;
    tick(2);
    chk(so, 8'hFF, "mr asserts");
    mr_n = 1'b1;
    expect_release();
    wr(8'h40, 8'h02);
    mr_n = 1'b0;
    tick(3);
    chk(so, 8'hFE, "mr independent");
    mr_n = 1'b1;
    tick(4);
    chk(so, 8'hFE, "mr alone is no dependency");
    $display("mr test done");
  endtask
  task automatic t_margin();
    wr(8'h14, 8'h01);
    wr(8'h41, 8'h03);
    wr(8'h42, 8'h02);
    wr(8'h40, 8'h01);
    tick(8);
    chk(so, 8'hFA, "output 3 released");
    mg_n = 1'b0;
    mr_n = 1'b0;
    set_src(0);
    tick(4);
    chk(so, 8'hFA, "margin force and freeze");
    mg_n = 1'b1;
    tick(3);
    chk(so, 8'hFF, "after margin");
    mr_n = 1'b1;
    set_src(9);
    tick(8);
    $display("margin test done");
  endtask
  // Output 1 with a longer timeout code, output 3 keeps the short one
  task automatic t_timeout();
    wr(8'h26, 8'h01);
    rd(8'h26, 8'h01, "timeout code readback");
    set_src(0);
    tick(2);
    chk(so, 8'hFF, "fault asserts both");
    set_src(9);
    tick(5);
    chk(so, 8'hFB, "longer timeout holds");
    tick(1);
    chk(so, 8'hFA, "longer timeout ends");
    $display("timeout test done");
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_nodep();
    t_release();
    t_mr();
    t_margin();
    t_timeout();
    wrap_up();
  end

  // Watchdog
  initial begin
    #50us;
    miscompares++;
    wrap_up();
  end
endmodule
